// [hw/lhc_pkg.sv]
package lhc_pkg;
  localparam logic [7:0] CMD_CSHAPE    = 8'h5d;
  localparam logic [7:0] CMD_CSTEP     = 8'h4c;
  localparam logic [7:0] CMD_CSTEP_MSK = 8'hfc;
  localparam logic [7:0] CMD_LMERGE    = 8'h5b;
  localparam logic [7:0] CMD_GLYPH     = 8'h5c;
  localparam logic [7:0] CMD_PSCROLL   = 8'h5a;
  localparam logic [7:0] CMD_CLOAD     = 8'h46;
  localparam logic [7:0] CMD_CFETCH    = 8'h47;
  localparam logic [7:0] CMD_DEPTH     = 8'h60;
  localparam logic [7:0] CMD_IDENT     = 8'h61;
  localparam logic [7:0] CMD_SYNTH     = 8'h62;
  localparam logic [7:0] CMD_PANEL     = 8'h63;
  localparam logic [7:0] REG_CURSOR_WIDTH  = 8'h15;
  localparam logic [7:0] REG_CURSOR_HEIGHT = 8'h16;
  localparam logic [7:0] REG_CURSOR_STEP   = 8'h17;
  localparam logic [7:0] REG_LAYER_OVERLAY = 8'h18;
  localparam logic [7:0] MASK_NONE     = 8'hff;
  localparam logic [7:0] MASK_LOW_NIB  = 8'h0f;
  localparam logic [7:0] MASK_HEIGHT   = 8'h8f;
  localparam logic [7:0] MASK_OVERLAY  = 8'h1f;
  localparam logic [7:0] MASK_HIGH7    = 8'h7f;
  localparam logic [7:0] MASK_SCROLL   = 8'h87;
  localparam logic [7:0] MASK_DEPTH    = 8'h03;
  localparam logic [7:0] MASK_PANEL    = 8'hf7;
  localparam logic [1:0] IDX_P1   = 2'h0;
  localparam logic [1:0] IDX_P2   = 2'h1;
  localparam logic [1:0] IDX_P3   = 2'h2;
  localparam logic [1:0] IDX_DONE = 2'h3;
  localparam logic [1:0] OP_CMD   = 2'h0;
  localparam logic [1:0] OP_PARAM = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [7:0] APB_OFS_OP     = 8'h00;
  localparam logic [7:0] APB_OFS_STATUS = 8'h04;

  // reserved-zero positions of each parameter byte; a zero bit is never driven or stored
  function automatic logic [7:0] param_mask(input logic [7:0] cmd, input logic [1:0] idx);
    param_mask = MASK_NONE;
    unique case (cmd)
      CMD_CSHAPE:  param_mask = (idx == IDX_P1) ? MASK_LOW_NIB : MASK_HEIGHT;
      CMD_LMERGE:  param_mask = MASK_OVERLAY;
      CMD_GLYPH:   param_mask = (idx == IDX_P1) ? MASK_NONE : MASK_HIGH7;
      CMD_CLOAD:   param_mask = (idx == IDX_P1) ? MASK_NONE : MASK_HIGH7;
      CMD_PSCROLL: param_mask = MASK_SCROLL;
      CMD_DEPTH:   param_mask = MASK_DEPTH;
      CMD_SYNTH:   param_mask = (idx == IDX_P3) ? MASK_HIGH7 : MASK_NONE;
      CMD_PANEL:   param_mask = MASK_PANEL;
      default:     param_mask = MASK_NONE;
    endcase
  endfunction
endpackage

// [hw/lhc_link_if.sv]
`timescale 1ns/100ps
interface lhc_link_if;
  logic       wr_en;
  logic       a0;
  logic [7:0] wdata;
  logic       rd_en;
  logic [7:0] rdata;
  logic       rvalid;

  modport dev (
    input  wr_en,
    input  a0,
    input  wdata,
    input  rd_en,
    output rdata,
    output rvalid
  );

  modport host (
    output wr_en,
    output a0,
    output wdata,
    output rd_en,
    input  rdata,
    input  rvalid
  );
endinterface

// [hw/lhc_device.sv]
// What this block does
// - cursor shape byte one sets width nibble
// - byte two sets style bit, height nibble
// - step commands copy low bits to direction
// - merge parameter bit 4 selects three layers
// - merge bits 3-2 select block display modes
// - merge bits 1-0 select layer mixing method
// - glyph base: low byte, then seven bits
// - scroll: update enable, amount, zeros between
// - cursor load: low byte, then seven bits
// - cursor fetch returns low, then seven bits
// - depth parameter low two bits select depth
// - identity command returns one fixed byte
// - synthesizer takes three packed field bytes
// - panel setup: polarities, zero, three options
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module lhc_device #(
  parameter logic [7:0] IDENT_CODE = 8'ha5  // arbitrary value
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  lhc_link_if.dev         lnk,
  output logic [7:0]      CURSOR_WIDTH,
  output logic [7:0]      CURSOR_HEIGHT_AND_MODE,
  output logic [7:0]      CURSOR_STEP_DIRECTION,
  output logic [7:0]      LAYER_OVERLAY_CONTROL,
  output logic [14:0]     GLYPH_BASE,
  output logic            SCROLL_UPDATE_EN,
  output logic [2:0]      SCROLL_AMOUNT,
  output logic [14:0]     CURSOR_ADDR,
  output logic [1:0]      DEPTH_SELECT,
  output logic [3:0]      SYNTH_OUT_RATIO,
  output logic [3:0]      SYNTH_IN_RATIO,
  output logic [3:0]      SYNTH_RANGE_SEL,
  output logic [3:0]      SYNTH_MULT,
  output logic [1:0]      SYNTH_VCO_SEL,
  output logic [4:0]      SYNTH_CTRL_FIELD,
  output logic            VERT_SYNC_POL,
  output logic            HORIZ_SYNC_POL,
  output logic            DATA_EN_POL,
  output logic            PIXCLK_POL,
  output logic [2:0]      PANEL_OPTIONS
);
  logic [7:0] cmd;
  logic [1:0] pidx;
  logic       cmd_wr;
  logic       par_wr;
  logic [7:0] pbyte;

  assign cmd_wr = lnk.wr_en && lnk.a0;
  assign par_wr = lnk.wr_en && !lnk.a0;
  assign pbyte  = lnk.wdata & lhc_pkg::param_mask(cmd, pidx);

  function automatic logic hit(input logic [7:0] code, input logic [1:0] idx);
    hit = par_wr && (cmd == code) && (pidx == idx);
  endfunction

  // a fresh command always rewinds; the count stops once past the last byte
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd  <= 8'h00;
      pidx <= lhc_pkg::IDX_P1;
    end else if (cmd_wr) begin
      cmd  <= lnk.wdata;
      pidx <= lhc_pkg::IDX_P1;
    end else if ((par_wr || lnk.rd_en) && pidx != lhc_pkg::IDX_DONE) begin
      pidx <= pidx + 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CURSOR_WIDTH           <= 8'h00;
      CURSOR_HEIGHT_AND_MODE <= 8'h00;
    end else begin
      if (hit(lhc_pkg::CMD_CSHAPE, lhc_pkg::IDX_P1)) begin
        CURSOR_WIDTH <= pbyte;
      end
      if (hit(lhc_pkg::CMD_CSHAPE, lhc_pkg::IDX_P2)) begin
        CURSOR_HEIGHT_AND_MODE <= pbyte;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CURSOR_STEP_DIRECTION <= 8'h00;
    end else if (cmd_wr && (lnk.wdata & lhc_pkg::CMD_CSTEP_MSK) == lhc_pkg::CMD_CSTEP) begin
      CURSOR_STEP_DIRECTION <= lnk.wdata & ~lhc_pkg::CMD_CSTEP_MSK;
    end
  end

  // overlay, block modes and mix method share one byte
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LAYER_OVERLAY_CONTROL <= 8'h00;
    end else if (hit(lhc_pkg::CMD_LMERGE, lhc_pkg::IDX_P1)) begin
      LAYER_OVERLAY_CONTROL <= pbyte;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      GLYPH_BASE <= 15'h0000;
    end else begin
      if (hit(lhc_pkg::CMD_GLYPH, lhc_pkg::IDX_P1)) begin
        GLYPH_BASE[7:0] <= pbyte;
      end
      if (hit(lhc_pkg::CMD_GLYPH, lhc_pkg::IDX_P2)) begin
        GLYPH_BASE[14:8] <= pbyte[6:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SCROLL_UPDATE_EN <= 1'b0;
      SCROLL_AMOUNT    <= 3'h0;
    end else if (hit(lhc_pkg::CMD_PSCROLL, lhc_pkg::IDX_P1)) begin
      SCROLL_UPDATE_EN <= pbyte[7];
      SCROLL_AMOUNT    <= pbyte[2:0];
    end
  end

  // half-written address is visible between the two bytes; no shadow copy
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CURSOR_ADDR <= 15'h0000;
    end else begin
      if (hit(lhc_pkg::CMD_CLOAD, lhc_pkg::IDX_P1)) begin
        CURSOR_ADDR[7:0] <= pbyte;
      end
      if (hit(lhc_pkg::CMD_CLOAD, lhc_pkg::IDX_P2)) begin
        CURSOR_ADDR[14:8] <= pbyte[6:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DEPTH_SELECT <= 2'h0;
    end else if (hit(lhc_pkg::CMD_DEPTH, lhc_pkg::IDX_P1)) begin
      DEPTH_SELECT <= pbyte[1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SYNTH_OUT_RATIO  <= 4'h0;
      SYNTH_IN_RATIO   <= 4'h0;
      SYNTH_RANGE_SEL  <= 4'h0;
      SYNTH_MULT       <= 4'h0;
      SYNTH_VCO_SEL    <= 2'h0;
      SYNTH_CTRL_FIELD <= 5'h00;
    end else begin
      if (hit(lhc_pkg::CMD_SYNTH, lhc_pkg::IDX_P1)) begin
        SYNTH_OUT_RATIO <= pbyte[7:4];
        SYNTH_IN_RATIO  <= pbyte[3:0];
      end
      if (hit(lhc_pkg::CMD_SYNTH, lhc_pkg::IDX_P2)) begin
        SYNTH_RANGE_SEL <= pbyte[7:4];
        SYNTH_MULT      <= pbyte[3:0];
      end
      if (hit(lhc_pkg::CMD_SYNTH, lhc_pkg::IDX_P3)) begin
        SYNTH_VCO_SEL    <= pbyte[6:5];
        SYNTH_CTRL_FIELD <= pbyte[4:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      VERT_SYNC_POL  <= 1'b0;
      HORIZ_SYNC_POL <= 1'b0;
      DATA_EN_POL    <= 1'b0;
      PIXCLK_POL     <= 1'b0;
      PANEL_OPTIONS  <= 3'h0;
    end else if (hit(lhc_pkg::CMD_PANEL, lhc_pkg::IDX_P1)) begin
      VERT_SYNC_POL  <= pbyte[7];
      HORIZ_SYNC_POL <= pbyte[6];
      DATA_EN_POL    <= pbyte[5];
      PIXCLK_POL     <= pbyte[4];
      PANEL_OPTIONS  <= pbyte[2:0];
    end
  end

  // reads outside a fetch or identity sequence answer zero rather than stall
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lnk.rdata  <= 8'h00;
      lnk.rvalid <= 1'b0;
    end else begin
      lnk.rvalid <= lnk.rd_en;
      if (lnk.rd_en) begin
        if (cmd == lhc_pkg::CMD_CFETCH && pidx == lhc_pkg::IDX_P1) begin
          lnk.rdata <= CURSOR_ADDR[7:0];
        end else if (cmd == lhc_pkg::CMD_CFETCH && pidx == lhc_pkg::IDX_P2) begin
          lnk.rdata <= {1'b0, CURSOR_ADDR[14:8]};
        end else if (cmd == lhc_pkg::CMD_IDENT && pidx == lhc_pkg::IDX_P1) begin
          lnk.rdata <= IDENT_CODE;
        end else begin
          lnk.rdata <= 8'h00;
        end
      end
    end
  end
endmodule

// [hw/lhc_apb_regs.sv]
`timescale 1ns/100ps
module lhc_apb_regs #(
  parameter int AW = 8
) (
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic               PREADY,
  output logic [31:0]        PRDATA,
  output logic               PSLVERR,
  output logic               op_valid,
  output logic [1:0]         op_kind,
  output logic [7:0]         op_byte,
  input  wire logic [7:0]    rd_byte,
  input  wire logic          rd_done
);
  logic access;
  logic [7:0] ofs;

  assign access = PSEL && PENABLE;
  assign ofs    = PADDR[7:0];

  // one wait state: answer decoded in the first access cycle, taken at the second edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access && !PREADY;
      if (access && !PREADY) begin
        PSLVERR <= !(ofs == lhc_pkg::APB_OFS_OP || ofs == lhc_pkg::APB_OFS_STATUS);
        PRDATA  <= (ofs == lhc_pkg::APB_OFS_STATUS && !PWRITE) ?
                   {23'h000000, rd_done, rd_byte} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      op_valid <= 1'b0;
      op_kind  <= 2'h0;
      op_byte  <= 8'h00;
    end else begin
      op_valid <= access && PREADY && PWRITE && ofs == lhc_pkg::APB_OFS_OP;
      if (access && PREADY && PWRITE && ofs == lhc_pkg::APB_OFS_OP) begin
        op_kind <= PWDATA[9:8];
        op_byte <= PWDATA[7:0];
      end
    end
  end
endmodule

// [hw/lhc_host.sv]
`timescale 1ns/100ps
module lhc_host (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  lhc_link_if.host         lnk
);
  logic       op_valid;
  logic [1:0] op_kind;
  logic [7:0] op_byte;
  logic [7:0] rd_byte;
  logic       rd_done;
  logic [7:0] cmd;
  logic [1:0] pidx;

  lhc_apb_regs #(.AW(8)) u_regs (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .PSEL     (PSEL),
    .PENABLE  (PENABLE),
    .PWRITE   (PWRITE),
    .PADDR    (PADDR),
    .PWDATA   (PWDATA),
    .PREADY   (PREADY),
    .PRDATA   (PRDATA),
    .PSLVERR  (PSLVERR),
    .op_valid (op_valid),
    .op_kind  (op_kind),
    .op_byte  (op_byte),
    .rd_byte  (rd_byte),
    .rd_done  (rd_done)
  );

  // mirror of the device's position so reserved bits can be forced to zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd  <= 8'h00;
      pidx <= lhc_pkg::IDX_P1;
    end else if (op_valid && op_kind == lhc_pkg::OP_CMD) begin
      cmd  <= op_byte;
      pidx <= lhc_pkg::IDX_P1;
    end else if (op_valid && (op_kind == lhc_pkg::OP_PARAM || op_kind == lhc_pkg::OP_READ)
                 && pidx != lhc_pkg::IDX_DONE) begin
      pidx <= pidx + 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lnk.wr_en <= 1'b0;
      lnk.a0    <= 1'b0;
      lnk.wdata <= 8'h00;
      lnk.rd_en <= 1'b0;
    end else begin
      lnk.wr_en <= op_valid && (op_kind == lhc_pkg::OP_CMD || op_kind == lhc_pkg::OP_PARAM);
      lnk.rd_en <= op_valid && op_kind == lhc_pkg::OP_READ;
      if (op_valid && op_kind == lhc_pkg::OP_CMD) begin
        lnk.a0    <= 1'b1;
        lnk.wdata <= op_byte;
      end else if (op_valid && op_kind == lhc_pkg::OP_PARAM) begin
        lnk.a0    <= 1'b0;
        lnk.wdata <= op_byte & lhc_pkg::param_mask(cmd, pidx);
      end
    end
  end

  // done is sticky; a new answer in the clearing cycle wins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_byte <= 8'h00;
      rd_done <= 1'b0;
    end else if (lnk.rvalid) begin
      rd_byte <= lnk.rdata;
      rd_done <= 1'b1;
    end else if (op_valid) begin
      rd_done <= 1'b0;
    end
  end
endmodule

// [tb/lhc_link_chk.sv]
`timescale 1ns/100ps
module lhc_link_chk #(
  parameter logic [7:0] IDENT_CODE = 8'ha5  // arbitrary value
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       wr_en,
  input wire logic       a0,
  input wire logic [7:0] wdata,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  logic [7:0]  last_cmd;
  logic [1:0]  pidx;
  logic [14:0] caddr;
  logic [7:0]  rsv;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // index counts reads and writes alike, saturating like the device
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      last_cmd <= 8'h00;
      pidx     <= 2'h0;
    end else if (wr_en && a0) begin
      last_cmd <= wdata;
      pidx     <= 2'h0;
    end else if (((wr_en && !a0) || rd_en) && pidx != 2'h3) begin
      pidx <= pidx + 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      caddr <= 15'h0000;
    end else if (wr_en && !a0 && last_cmd == 8'h46 && pidx == 2'h0) begin
      caddr[7:0] <= wdata;
    end else if (wr_en && !a0 && last_cmd == 8'h46 && pidx == 2'h1) begin
      caddr[14:8] <= wdata[6:0];
    end
  end

  // only one-parameter commands, so no index is needed here
  always_comb begin
    case (last_cmd)
      8'h5a:   rsv = 8'h78;
      8'h5b:   rsv = 8'he0;
      8'h60:   rsv = 8'hfc;
      8'h63:   rsv = 8'h08;
      default: rsv = 8'h00;
    endcase
  end

  chk_rvalid_follows: assert property (rd_en |=> rvalid)
    else $error("rvalid missing after rd_en");
  chk_rvalid_cause: assert property (rvalid |-> $past(rd_en))
    else $error("rvalid without rd_en");
  chk_rdata_hold: assert property (!rd_en |=> $stable(rdata))
    else $error("rdata moved without rd_en");
  chk_ident_byte: assert property (rd_en && last_cmd == 8'h61 && pidx == 2'h0 |=> rdata == IDENT_CODE)
    else $error("identity byte wrong");
  chk_fetch_low: assert property (rd_en && last_cmd == 8'h47 && pidx == 2'h0 |=> rdata == caddr[7:0])
    else $error("cursor low byte wrong");
  chk_fetch_high: assert property (rd_en && last_cmd == 8'h47 && pidx == 2'h1 |=> rdata == {1'b0, caddr[14:8]})
    else $error("cursor high byte wrong");
  chk_strobe_single: assert property (wr_en |=> !wr_en && !rd_en)
    else $error("byte strobes too close");
  chk_param_reserved: assert property (wr_en && !a0 |-> (wdata & rsv) == 8'h00)
    else $error("reserved parameter bit driven");
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] ID_VAL = 8'h3c;  // arbitrary value
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] r;
  logic        e;
  logic [7:0]  b;
  int          errors;
  int          cmp_count;

  lhc_link_if lnk ();
  lhc_host lhc_host_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .lnk(lnk));
  lhc_device #(.IDENT_CODE(ID_VAL)) lhc_device_inst (.CLK(clk), .RST_N(rst_n), .lnk(lnk),
    .CURSOR_WIDTH(), .CURSOR_HEIGHT_AND_MODE(), .CURSOR_STEP_DIRECTION(), .LAYER_OVERLAY_CONTROL(),
    .GLYPH_BASE(), .SCROLL_UPDATE_EN(), .SCROLL_AMOUNT(), .CURSOR_ADDR(), .DEPTH_SELECT(),
    .SYNTH_OUT_RATIO(), .SYNTH_IN_RATIO(), .SYNTH_RANGE_SEL(), .SYNTH_MULT(), .SYNTH_VCO_SEL(),
    .SYNTH_CTRL_FIELD(), .VERT_SYNC_POL(), .HORIZ_SYNC_POL(), .DATA_EN_POL(), .PIXCLK_POL(), .PANEL_OPTIONS());
  lhc_link_chk #(.IDENT_CODE(ID_VAL)) lhc_link_chk_inst (.CLK(clk), .RST_N(rst_n), .wr_en(lnk.wr_en),
    .a0(lnk.a0), .wdata(lnk.wdata), .rd_en(lnk.rd_en), .rdata(lnk.rdata), .rvalid(lnk.rvalid));

  always #2.5 clk = ~clk;

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // slave answer time is not assumed; only the watchdog ends a wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task op(input logic [1:0] k, input logic [7:0] v);
    logic [31:0] x;
    logic        y;
    apb(1'b1, 8'h00, {22'h0, k, v}, x, y);
  endtask

  task send(input logic [7:0] c, input int n, input logic [7:0] p0, p1, p2);
    op(2'h0, c);
    if (n > 0) op(2'h1, p0);
    if (n > 1) op(2'h1, p1);
    if (n > 2) op(2'h1, p2);
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // poll the sticky done flag rather than trusting a cycle count
  task rd_byte(output logic [7:0] v);
    op(2'h2, 8'h00);
    do begin
      apb(1'b0, 8'h04, 32'h0, r, e);
    end while (r[8] !== 1'b1);
    v = r[7:0];
  endtask

  task tend(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("reset", 32'({lhc_device_inst.CURSOR_WIDTH, lhc_device_inst.CURSOR_ADDR}), 32'h0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    check("status", r, 32'h0);
    tend("reset");
    send(8'h5d, 2, 8'hff, 8'hff, 8'h00);
    check("width", 32'(lhc_device_inst.CURSOR_WIDTH), 32'h0f);
    check("height", 32'(lhc_device_inst.CURSOR_HEIGHT_AND_MODE), 32'h8f);
    for (int i = 0; i < 4; i++) begin
      send(8'h4c + 8'(i), 0, 8'h00, 8'h00, 8'h00);
      check("step", 32'(lhc_device_inst.CURSOR_STEP_DIRECTION), 32'(i));
    end
    send(8'h5b, 1, 8'hff, 8'h00, 8'h00);
    check("overlay", 32'(lhc_device_inst.LAYER_OVERLAY_CONTROL), 32'h1f);
    send(8'h5b, 1, 8'h0a, 8'h00, 8'h00);
    check("overlay", 32'(lhc_device_inst.LAYER_OVERLAY_CONTROL), 32'h0a);
    tend("cursor_layer");
    send(8'h5c, 2, 8'h34, 8'h92, 8'h00);
    check("glyph", 32'(lhc_device_inst.GLYPH_BASE), 32'h1234);
    send(8'h5a, 1, 8'h85, 8'h00, 8'h00);
    check("scroll", 32'({lhc_device_inst.SCROLL_UPDATE_EN, lhc_device_inst.SCROLL_AMOUNT}), 32'hd);
    send(8'h5a, 1, 8'h7a, 8'h00, 8'h00);
    check("scroll", 32'({lhc_device_inst.SCROLL_UPDATE_EN, lhc_device_inst.SCROLL_AMOUNT}), 32'h2);
    send(8'h60, 1, 8'hfe, 8'h00, 8'h00);
    check("depth", 32'(lhc_device_inst.DEPTH_SELECT), 32'h2);
    tend("glyph_scroll_depth");
    send(8'h46, 2, 8'hcd, 8'hab, 8'h00);
    check("caddr", 32'(lhc_device_inst.CURSOR_ADDR), 32'h2bcd);
    send(8'h47, 0, 8'h00, 8'h00, 8'h00);
    rd_byte(b);
    check("fetch_lo", 32'(b), 32'hcd);
    rd_byte(b);
    check("fetch_hi", 32'(b), 32'h2b);
    send(8'h61, 0, 8'h00, 8'h00, 8'h00);
    rd_byte(b);
    check("ident", 32'(b), 32'(ID_VAL));
    tend("readback");
    send(8'h62, 3, 8'ha5, 8'h3c, 8'hff);
    check("synth", 32'({lhc_device_inst.SYNTH_OUT_RATIO, lhc_device_inst.SYNTH_IN_RATIO,
      lhc_device_inst.SYNTH_RANGE_SEL, lhc_device_inst.SYNTH_MULT, lhc_device_inst.SYNTH_VCO_SEL,
      lhc_device_inst.SYNTH_CTRL_FIELD}), 32'({4'ha, 4'h5, 4'h3, 4'hc, 2'h3, 5'h1f}));
    send(8'h63, 1, 8'hff, 8'h00, 8'h00);
    check("panel", 32'({lhc_device_inst.VERT_SYNC_POL, lhc_device_inst.HORIZ_SYNC_POL, lhc_device_inst.DATA_EN_POL,
      lhc_device_inst.PIXCLK_POL, lhc_device_inst.PANEL_OPTIONS}), 32'h7f);
    send(8'h63, 1, 8'h5a, 8'h00, 8'h00);
    check("panel", 32'({lhc_device_inst.VERT_SYNC_POL, lhc_device_inst.HORIZ_SYNC_POL, lhc_device_inst.DATA_EN_POL,
      lhc_device_inst.PIXCLK_POL, lhc_device_inst.PANEL_OPTIONS}), 32'h2a);
    tend("synth_panel");
    send(8'h46, 1, 8'h11, 8'h00, 8'h00);
    send(8'h5c, 2, 8'h22, 8'h33, 8'h00);
    check("caddr", 32'(lhc_device_inst.CURSOR_ADDR), 32'h2b11);
    check("glyph", 32'(lhc_device_inst.GLYPH_BASE), 32'h3322);
    send(8'h60, 3, 8'h01, 8'h03, 8'h02);
    check("depth", 32'(lhc_device_inst.DEPTH_SELECT), 32'h1);
    apb(1'b0, 8'h08, 32'h0, r, e);
    check("unmapped_err", 32'(e), 32'h1);
    check("unmapped_data", r, 32'h0);
    // status is read-only; op writes since the last read cleared done
    apb(1'b1, 8'h04, 32'h1ff, r, e);
    check("status_wr_err", 32'(e), 32'h0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    check("status_keep", r, 32'(ID_VAL));
    tend("order_refuse");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("rerun_reset", 32'({lhc_device_inst.CURSOR_WIDTH, lhc_device_inst.CURSOR_ADDR}), 32'h0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    check("rerun_status", r, 32'h0);
    tend("mid_reset");
    close_out;
  end

  // whole sequence needs a few hundred cycles
  initial begin
    #50000;
    errors++;
    close_out;
  end
endmodule
